// >>> shared/emb_consts.svh
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH
// ============================================================
// register map
`define EMB_ADDR_PERIOD_OR_CTRL 4'h0
`define EMB_ADDR_WDT_CTRL       4'h1
`define EMB_ADDR_PORT_G         4'h2
`define EMB_ADDR_STATUS         4'h3
// ============================================================
// control register fields
`define EMB_BIT_RELEASE         7
`define EMB_WAIT_HI             5
`define EMB_WAIT_LO             4
`define EMB_STYLE_HI            1
`define EMB_STYLE_LO            0
`define EMB_CTRL_MASK           8'h_b3
`define EMB_CTRL_RESET          8'h_00
`define EMB_PERIOD_RESET        8'h_ff
`define EMB_BIT_SHARED_SEL      4
`define EMB_WDT_RESET           8'h_00
`define EMB_PULLUP_HI           7
`define EMB_PULLUP_LO           5
`define EMB_PORT_G_RESET        8'h_00
// ============================================================
// configuration encodings
`define EMB_AW_20               2'b00
`define EMB_AW_16               2'b01
`define EMB_AW_12               2'b10
`define EMB_AW_INTERNAL         2'b11
`define EMB_ONCHIP_SIZE         21'h01_0000
`define EMB_WAIT_MAX            2'd3
`endif

// >>> shared/emb_pkg.sv
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_IDLE = 2'b00,
    EMB_XFER = 2'b01,
    EMB_WAIT = 2'b11
  } emb_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } emb_regbus_s;
  typedef struct packed {
    logic        fetch;
    logic        table_rd;
    logic        table_wr;
    logic        external;
    logic [20:0] pc;
    logic [7:0]  table_latch;
  } emb_core_req_s;
endpackage

// >>> rtl/emb_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "emb_consts.svh"
// Overview of operation
// - internal-only mode ignores control writes
// - release clear keeps bus always active
// - release set uses bus only when needed
// - release bit resets to zero
// - wait code 11..00 adds 0..3 cycles
// - wait cycles only when enabled, after op
// - byte select: copy byte, high strobe, enable
// - word write: full word, high strobe
// - byte write: copy byte, one strobe
// - write style ignored for 8-bit data
// - control shares address with timer period
// - data width fixed by config bit
// - config field sets address width, mode
// - unused high address lines stay plain I/O
// - 12-bit address hides upper data bits
// - data multiplexed onto low address lines
// - no shift drives program counter unchanged
// - shift subtracts on-chip memory size
// - 20-bit mode drives byte address lsb
// - upper and lower byte enables provided
// - port bits 7-5 enable lane pull-ups
// - reset clears all pull-up enables
// - release waits until internal execution
module emb_ctrl
  import emb_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_b_in,
  input  wire emb_regbus_s   reg_bus_in,
  output logic [7:0]         reg_rdata_out,
  input  wire emb_core_req_s core_req_in,
  input  wire logic          data_width_select_in,
  input  wire logic [1:0]    address_width_mode_in,
  input  wire logic          address_offset_enable_in,
  input  wire logic          wait_enable_in,
  input  wire logic [19:0]   io_out_in,
  input  wire logic [19:0]   io_oe_in,
  input  wire logic [15:0]   ad_in,
  output logic [19:0]        ad_out,
  output logic [19:0]        ad_oe_out,
  output logic [15:0]        read_data_out,
  output logic               read_valid_out,
  output logic               core_stall_out,
  output logic               bus_owns_pins_out,
  output logic               write_high_strobe_b_out,
  output logic               write_low_strobe_b_out,
  output logic               upper_byte_enable_b_out,
  output logic               lower_byte_enable_b_out,
  output logic               byte_address_lsb_out,
  output logic               chip_enable_b_out,
  output logic [2:0]         pullup_en_out
);
  // ============================================================
  // registers
  logic [7:0]  ctrl_reg;
  logic [7:0]  period_reg;
  logic [7:0]  wdt_reg;
  logic [7:0]  port_g_reg;
  logic        release_eff_reg;
  logic        rd_pending_reg;
  logic [7:0]  hold_reg;
  logic [1:0]  wait_cnt_reg;
  emb_state_e  state_reg;
  logic        internal_only;
  logic        ctrl_sel;
  logic        access;
  logic        wide;
  logic [1:0]  wait_code;
  logic [1:0]  wait_cycles;
  logic [1:0]  style;
  logic [20:0] bus_addr;
  logic [19:0] addr_lines;
  logic [19:0] lane_used;
  logic        owns;
  logic [15:0] wdata_next;
  logic        wr_data_drive;
  logic        strobe_hi;
  logic        strobe_lo;
  logic        ub_act;
  logic        lb_act;

  assign internal_only = (address_width_mode_in == `EMB_AW_INTERNAL);
  assign ctrl_sel = wdt_reg[`EMB_BIT_SHARED_SEL];
  assign wide = data_width_select_in;
  assign style = ctrl_reg[`EMB_STYLE_HI:`EMB_STYLE_LO];
  assign wait_code = ctrl_reg[`EMB_WAIT_HI:`EMB_WAIT_LO];
  assign wait_cycles = `EMB_WAIT_MAX - wait_code;
  assign access = !internal_only && core_req_in.external
                  && (core_req_in.fetch || core_req_in.table_rd || core_req_in.table_wr);

  // ============================================================
  // register writes
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= `EMB_CTRL_RESET;
    end else if (reg_bus_in.wr && !internal_only && ctrl_sel
                 && reg_bus_in.addr == `EMB_ADDR_PERIOD_OR_CTRL) begin
      ctrl_reg <= reg_bus_in.wdata & `EMB_CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      period_reg <= `EMB_PERIOD_RESET;
    end else if (reg_bus_in.wr && !ctrl_sel
                 && reg_bus_in.addr == `EMB_ADDR_PERIOD_OR_CTRL) begin
      period_reg <= reg_bus_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdt_reg <= `EMB_WDT_RESET;
    end else if (reg_bus_in.wr && reg_bus_in.addr == `EMB_ADDR_WDT_CTRL) begin
      wdt_reg <= reg_bus_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_g_reg <= `EMB_PORT_G_RESET;
    end else if (reg_bus_in.wr && reg_bus_in.addr == `EMB_ADDR_PORT_G) begin
      port_g_reg <= reg_bus_in.wdata;
    end
  end

  // ============================================================
  // register reads
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h_00;
    end else if (reg_bus_in.rd) begin
      if (reg_bus_in.addr == `EMB_ADDR_PERIOD_OR_CTRL) begin
        reg_rdata_out <= ctrl_sel ? ctrl_reg : period_reg;
      end else if (reg_bus_in.addr == `EMB_ADDR_WDT_CTRL) begin
        reg_rdata_out <= wdt_reg;
      end else if (reg_bus_in.addr == `EMB_ADDR_PORT_G) begin
        reg_rdata_out <= port_g_reg;
      end else if (reg_bus_in.addr == `EMB_ADDR_STATUS) begin
        reg_rdata_out <= {5'h_00, release_eff_reg, state_reg};
      end else begin
        reg_rdata_out <= 8'h_00;
      end
    end
  end

  // ============================================================
  // release takes effect only from internal code
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      release_eff_reg <= 1'b0;
    end else if (!(core_req_in.fetch && core_req_in.external)) begin
      release_eff_reg <= ctrl_reg[`EMB_BIT_RELEASE];
    end
  end

  // ============================================================
  // address
  always_comb begin
    if (address_offset_enable_in) begin
      bus_addr = core_req_in.pc - `EMB_ONCHIP_SIZE;
    end else begin
      bus_addr = core_req_in.pc;
    end
  end
  // word lines carry bus_addr[20:1]; lsb goes on its own pin
  assign addr_lines = bus_addr[20:1];

  always_comb begin
    if (address_width_mode_in == `EMB_AW_20) begin
      lane_used = 20'h_f_ffff;
    end else if (address_width_mode_in == `EMB_AW_16) begin
      lane_used = 20'h_0_ffff;
    end else if (address_width_mode_in == `EMB_AW_12) begin
      lane_used = 20'h_0_0fff;
    end else begin
      lane_used = 20'h_0_0000;
    end
  end

  assign owns = !internal_only && (!release_eff_reg || access || state_reg != EMB_IDLE);

  // ============================================================
  // write data and strobes
  always_comb begin
    wdata_next    = {core_req_in.table_latch, core_req_in.table_latch};
    wr_data_drive = 1'b1;
    strobe_hi     = 1'b0;
    strobe_lo     = 1'b0;
    ub_act        = 1'b1;
    lb_act        = 1'b1;
    if (core_req_in.table_wr && access) begin
      if (!wide) begin
        strobe_lo = 1'b1;
      end else if (style[1]) begin
        wdata_next    = {core_req_in.table_latch, hold_reg};
        wr_data_drive = bus_addr[0];
        strobe_hi     = bus_addr[0];
      end else if (style == 2'b01) begin
        strobe_hi = 1'b1;
        ub_act    = bus_addr[0];
        lb_act    = !bus_addr[0];
      end else begin
        strobe_hi = bus_addr[0];
        strobe_lo = !bus_addr[0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_reg <= 8'h_00;
    end else if (core_req_in.table_wr && access && !bus_addr[0]) begin
      hold_reg <= core_req_in.table_latch;
    end
  end

  // ============================================================
  // read return: memory answers only once the strobes are on the pins
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_pending_reg <= 1'b0;
    end else begin
      rd_pending_reg <= access && core_req_in.table_rd;
    end
  end

  // ============================================================
  // wait state sequencer
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg    <= EMB_IDLE;
      wait_cnt_reg <= 2'd0;
    end else begin
      case (state_reg)
        EMB_IDLE: begin
          if (access && (core_req_in.table_rd || core_req_in.table_wr)) begin
            state_reg <= EMB_XFER;
          end
        end
        EMB_XFER: begin
          if (wait_enable_in && wait_cycles != 2'd0) begin
            state_reg    <= EMB_WAIT;
            wait_cnt_reg <= wait_cycles;
          end else begin
            state_reg <= EMB_IDLE;
          end
        end
        EMB_WAIT: begin
          if (wait_cnt_reg == 2'd1) begin
            state_reg <= EMB_IDLE;
          end
          wait_cnt_reg <= wait_cnt_reg - 2'd1;
        end
        default: begin
          state_reg <= EMB_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // pins, all registered
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ad_out                  <= 20'h_0_0000;
      ad_oe_out               <= 20'h_0_0000;
      read_data_out           <= 16'h_0000;
      read_valid_out          <= 1'b0;
      core_stall_out          <= 1'b0;
      bus_owns_pins_out       <= 1'b0;
      write_high_strobe_b_out <= 1'b1;
      write_low_strobe_b_out  <= 1'b1;
      upper_byte_enable_b_out <= 1'b1;
      lower_byte_enable_b_out <= 1'b1;
      byte_address_lsb_out    <= 1'b0;
      chip_enable_b_out       <= 1'b1;
      pullup_en_out           <= 3'b000;
    end else begin
      pullup_en_out     <= port_g_reg[`EMB_PULLUP_HI:`EMB_PULLUP_LO];
      bus_owns_pins_out <= owns;
      core_stall_out    <= (state_reg == EMB_XFER && wait_enable_in && wait_cycles != 2'd0)
                           || (state_reg == EMB_WAIT && wait_cnt_reg != 2'd1);
      read_valid_out    <= rd_pending_reg;
      if (wide) begin
        read_data_out <= ad_in & lane_used[15:0];
      end else begin
        read_data_out <= {8'h_00, ad_in[7:0]};
      end
      for (int i = 0; i < 20; i++) begin
        if (owns && lane_used[i]) begin
          if (access && core_req_in.table_wr && i < 16 && (wide || i < 8)) begin
            ad_out[i]    <= wdata_next[i];
            ad_oe_out[i] <= wr_data_drive;
          end else begin
            ad_out[i]    <= addr_lines[i];
            ad_oe_out[i] <= access && !core_req_in.table_rd;
          end
        end else begin
          ad_out[i]    <= io_out_in[i];
          ad_oe_out[i] <= io_oe_in[i];
        end
      end
      write_high_strobe_b_out <= !strobe_hi;
      write_low_strobe_b_out  <= !strobe_lo;
      upper_byte_enable_b_out <= !(access && ub_act);
      lower_byte_enable_b_out <= !(access && lb_act);
      byte_address_lsb_out    <= access && bus_addr[0];
      chip_enable_b_out       <= !access;
    end
  end
endmodule // emb_ctrl
`default_nettype wire

// >>> testbench/emb_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// bus controller properties
module emb_ctrl_properties
  import emb_pkg::*;
(
  input wire logic          sys_clk_in,
  input wire logic          rst_b_in,
  input wire emb_regbus_s   reg_bus_in,
  input wire emb_core_req_s core_req_in,
  input wire logic          data_width_select_in,
  input wire logic [1:0]    address_width_mode_in,
  input wire logic          wait_enable_in,
  input wire logic          core_stall_out,
  input wire logic          bus_owns_pins_out,
  input wire logic          write_high_strobe_b_out,
  input wire logic          write_low_strobe_b_out,
  input wire logic          byte_address_lsb_out,
  input wire logic          chip_enable_b_out,
  input wire logic [2:0]    pullup_en_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_pullup_reset:
    assert property ($rose(rst_b_in) |-> pullup_en_out == 3'b000)
    else $error("pull-ups set after reset");
  chk_release_default:
    assert property ($rose(rst_b_in) && address_width_mode_in != 2'b11 |-> ##2 bus_owns_pins_out)
    else $error("bus not owning pins after reset");
  chk_pullup_write:
    assert property (reg_bus_in.wr && reg_bus_in.addr == 4'h2
      |-> ##2 pullup_en_out == $past(reg_bus_in.wdata[7:5], 2))
    else $error("pull-ups do not follow port write");
  chk_wait_max:
    assert property (core_stall_out [*3] |=> !core_stall_out)
    else $error("more than three wait cycles");
  chk_wait_off:
    assert property (!wait_enable_in |-> !core_stall_out)
    else $error("stall with waits disabled");
  chk_internal_ce:
    assert property (address_width_mode_in == 2'b11 |=> chip_enable_b_out)
    else $error("chip enable in internal mode");
  chk_one_strobe:
    assert property (write_high_strobe_b_out || write_low_strobe_b_out)
    else $error("both write strobes low");
  chk_odd_high:
    assert property (core_req_in.table_wr && core_req_in.external && core_req_in.pc[0]
      && data_width_select_in && address_width_mode_in != 2'b11 |=> !write_high_strobe_b_out)
    else $error("odd write without high strobe");
  chk_byte_lsb:
    assert property (core_req_in.fetch && core_req_in.external && address_width_mode_in == 2'b00
      |=> byte_address_lsb_out == $past(core_req_in.pc[0]))
    else $error("byte address lsb wrong");
endmodule // emb_ctrl_properties
`default_nettype wire

// >>> testbench/emb_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// word-wide external memory, one word deep
module emb_ext_mem (
  input  wire logic        sys_clk_in,
  input  wire logic [19:0] bus_in,
  input  wire logic        ce_b_in,
  input  wire logic        wrh_b_in,
  input  wire logic        ub_b_in,
  output logic      [15:0] data_out
);
  logic [15:0] word_reg = 16'ha5c3;
  always_ff @(posedge sys_clk_in) begin
    if (!wrh_b_in && !ub_b_in) begin
      word_reg <= bus_in[15:0];
    end
  end
  // deselected: inverted word, so a stale value never passes
  assign data_out = ce_b_in ? ~word_reg : word_reg;
endmodule // emb_ext_mem
`default_nettype wire

// >>> testbench/test_emb_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// bench for the external bus controller
module test_emb_ctrl
  import emb_pkg::*;
;
  localparam logic [2:0] FE = 3'b100, TR = 3'b010, TW = 3'b001;
  logic          sys_clk_in = 1'b0;
  logic          rst_b_in = 1'b0;
  emb_regbus_s   reg_bus_in = '0;
  emb_core_req_s core_req_in = '0;
  logic          data_width_select_in = 1'b1;
  logic [1:0]    address_width_mode_in = 2'b00;
  logic          address_offset_enable_in = 1'b0;
  logic          wait_enable_in = 1'b1;
  logic [19:0]   io_out_in = 20'h5_a5a5;
  logic [19:0]   io_oe_in = 20'ha_0000;
  logic [15:0]   ad_in, read_data_out;
  logic [19:0]   ad_out, ad_oe_out;
  logic [7:0]    reg_rdata_out;
  logic          read_valid_out, core_stall_out, bus_owns_pins_out, chip_enable_b_out;
  logic          write_high_strobe_b_out, write_low_strobe_b_out, byte_address_lsb_out;
  logic          upper_byte_enable_b_out, lower_byte_enable_b_out;
  logic [2:0]    pullup_en_out;
  int            fail_count = 0, tests_run = 0, n;
  wire  [17:0]   wbus = {ad_out[15:0], write_high_strobe_b_out, write_low_strobe_b_out};

  always #20 sys_clk_in = ~sys_clk_in;
  emb_ctrl dut (.*);
  emb_ext_mem u_mem (
    .sys_clk_in (sys_clk_in),
    .bus_in     (ad_out),
    .ce_b_in    (chip_enable_b_out),
    .wrh_b_in   (write_high_strobe_b_out),
    .ub_b_in    (upper_byte_enable_b_out),
    .data_out   (ad_in)
  );
  // ============================================================
  // tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic nx;
    @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_bus_in <= '{a, d, 1'b1, 1'b0};
    nx;
    reg_bus_in <= '0;
    nx;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_bus_in <= '{a, 8'h00, 1'b0, 1'b1};
    nx;
    reg_bus_in <= '0;
    #1 chk(reg_rdata_out, e);
    nx;
  endtask
  // leaves time 1 ns past the taking edge, caller checks then calls nx
  task automatic op(input logic [2:0] k, input logic [20:0] pc, input logic [7:0] l);
    core_req_in <= {k, 1'b1, pc, l};
    nx;
    core_req_in <= '0;
    #1;
  endtask
  task automatic stalls;
    n = 0;
    repeat (6) begin
      n += int'(core_stall_out === 1'b1);
      nx;
      #1;
    end
  endtask
  task end_sim;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ============================================================
  // tests
  initial begin
    repeat (6) nx;
    rst_b_in <= 1'b1;
    nx;
    #1 chk(bus_owns_pins_out, 1'b1);
    nx;
    rd(4'h0, 8'hff);
    wr(4'h1, 8'h10);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'hb3);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h12);
    wr(4'h1, 8'h10);
    rd(4'h0, 8'hb3);
    wr(4'h2, 8'ha0);
    #1 chk(pullup_en_out, 3'b101);
    nx;
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {2'b00, 2'(3 - i), 4'h0});
      op(TR, 21'h1_0000, 8'h00);
      stalls;
      chk(n, i);
    end
    wait_enable_in <= 1'b0;
    wr(4'h0, 8'h00);
    op(TR, 21'h1_0000, 8'h00);
    stalls;
    chk(n, 0);
    wait_enable_in <= 1'b1;
    $display("wait test done");
    wr(4'h0, 8'h30);
    op(TW, 21'h1_0001, 8'h3c);
    chk(wbus, {16'h3c3c, 2'b01});
    nx;
    op(TW, 21'h1_0000, 8'h3c);
    chk(wbus, {16'h3c3c, 2'b10});
    nx;
    wr(4'h0, 8'h31);
    op(TW, 21'h1_0001, 8'h3c);
    chk({wbus, byte_address_lsb_out, upper_byte_enable_b_out, lower_byte_enable_b_out},
        {16'h3c3c, 5'b01101});
    nx;
    wr(4'h0, 8'h32);
    op(TW, 21'h1_0000, 8'h11);
    chk(wbus[1:0], 2'b11);
    nx;
    op(TW, 21'h1_0001, 8'h22);
    chk(wbus, {16'h2211, 2'b01});
    nx;
    data_width_select_in <= 1'b0;
    op(TW, 21'h1_0000, 8'h5a);
    chk(ad_out[7:0], 8'h5a);
    nx;
    data_width_select_in <= 1'b1;
    op(TR, 21'h1_0001, 8'h00);
    nx;
    #1 chk({read_valid_out, read_data_out}, {1'b1, 16'h2211});
    nx;
    $display("write test done");
    op(FE, 21'h1_2345, 8'h00);
    chk({ad_out, byte_address_lsb_out}, {20'h0_91a2, 1'b1});
    nx;
    address_offset_enable_in <= 1'b1;
    op(FE, 21'h1_2345, 8'h00);
    chk({ad_out, byte_address_lsb_out}, {20'h0_11a2, 1'b1});
    nx;
    address_offset_enable_in <= 1'b0;
    address_width_mode_in <= 2'b01;
    op(FE, 21'h1_2345, 8'h00);
    chk({ad_out[19:16], ad_oe_out[19:16]}, 8'h5a);
    nx;
    address_width_mode_in <= 2'b00;
    // release requested while running externally must wait
    core_req_in <= {FE, 1'b1, 21'h1_2345, 8'h00};
    wr(4'h0, 8'hb0);
    #1 chk(bus_owns_pins_out, 1'b1);
    nx;
    core_req_in <= '0;
    repeat (3) nx;
    #1 chk(bus_owns_pins_out, 1'b0);
    nx;
    op(FE, 21'h1_2345, 8'h00);
    chk(bus_owns_pins_out, 1'b1);
    nx;
    address_width_mode_in <= 2'b11;
    wr(4'h0, 8'h01);
    rd(4'h0, 8'hb0);
    op(FE, 21'h1_2345, 8'h00);
    chk(chip_enable_b_out, 1'b1);
    nx;
    $display("address test done");
    end_sim;
  end
  // whole sequence needs well under 300 cycles
  initial begin
    #100000;
    fail_count++;
    end_sim;
  end
endmodule // test_emb_ctrl
bind emb_ctrl emb_ctrl_properties u_props (.*);
`default_nettype wire
